//--- quad_dac_update.sv
// Two-wire slave receiver, command decode and double-buffered channel registers
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_params.svh"
// Behaviour
// RL1 - first byte after address is command
// RL2 - mode 00 writes staging by channel
// RL3 - power-down select stores code upper bits
// RL4 - mode 01 writes staging and output
// RL5 - mode 01 with power-down powers channel
// RL6 - mode 10 writes staging, loads all
// RL7 - broadcast, upper pick clear: load stored
// RL8 - broadcast with data loads all outputs
// RL9 - broadcast power-down applies to all
// RL10 - high byte is code bits 11..4
// RL11 - low byte upper nibble is bits 3..0
// RL12 - update at end of final ack
// RL13 - readback state cleared at reset
// RL14 - load pin rise copies all staging
// RL15 - master pulses load pin after writes
// RL16 - each channel has 14-bit staging
// RL17 - each channel has 14-bit output
// RL18 - respond only to own seven-bit address
// RL19 - data pairs repeat until stop/start
// RL20 - power-down sends exactly two bytes
// RL21 - address carries device select pins
// RL22 - bit three ignored; registers reset zero
module quad_dac_update
  import quad_dac_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic device_select_upper_i,
  input wire logic device_select_lower_i,
  input wire logic async_update_pin_i,
  output logic [13:0] output_channel_a_o,
  output logic [13:0] output_channel_b_o,
  output logic [13:0] output_channel_c_o,
  output logic [13:0] output_channel_d_o
);
  // ==========================================================
  // Pin synchronisers
  logic [4:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic upd_s;
  logic [1:0] sel_s;
  pin_sync #(.WIDTH(5)) u_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .pin_i({scl_i, sda_i, async_update_pin_i, device_select_upper_i,
      device_select_lower_i}),
    .sync_o(pins_s)
  );
  assign {scl_s, sda_s, upd_s, sel_s} = pins_s;

  // ==========================================================
  // Link edge detection
  logic scl_q;
  logic sda_q;
  logic upd_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic upd_rise;
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det = scl_s && scl_q && !sda_q && sda_s;
  assign upd_rise = upd_s && !upd_q;
  // Previous samples for edge finding
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      upd_q <= 1'b0;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      upd_q <= upd_s;
    end
  end

  // ==========================================================
  // Byte receiver and acknowledge
  link_phase_e phase_r;
  link_phase_e phase_nxt;
  byte_seq_e seq_r;
  byte_seq_e seq_nxt;
  byte_seq_e seq_after;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic first_r;
  logic first_nxt;
  logic pd_seq_r;
  logic pd_seq_nxt;
  logic oe_n_r;
  logic oe_n_nxt;
  logic push;
  logic in_ready;
  logic addr_match;
  logic byte_ok;
  // Own address with write direction only; other traffic is not acked
  assign addr_match = (shift_r[7:1] == {`DEV_ADDR_PREFIX, sel_s}) && !shift_r[0]; // RL18 RL21
  // A power-down transfer takes no bytes beyond its pair
  assign byte_ok = first_r ? addr_match : (seq_r != SEQ_DONE) && in_ready; // RL20
  // Byte order after the command: high, low, high, low ...
  always_comb
  begin
    unique case (seq_r)
      SEQ_CMD: seq_after = SEQ_HI;
      SEQ_HI: seq_after = SEQ_LO;
      SEQ_LO: seq_after = pd_seq_r ? SEQ_DONE : SEQ_HI; // RL19 RL20
      SEQ_DONE: seq_after = SEQ_DONE;
      default: seq_after = SEQ_DONE;
    endcase
  end
  // Framing: start or repeated start restarts, stop ends the transfer
  always_comb
  begin
    phase_nxt = phase_r;
    seq_nxt = seq_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    first_nxt = first_r;
    pd_seq_nxt = pd_seq_r;
    oe_n_nxt = oe_n_r;
    push = 1'b0;
    if (start_det)
    begin
      phase_nxt = PH_RX;
      bit_cnt_nxt = 4'h0;
      first_nxt = 1'b1;
      oe_n_nxt = 1'b1;
    end
    else if (stop_det)
    begin
      phase_nxt = PH_IDLE;
      oe_n_nxt = 1'b1;
    end
    else
    begin
      unique case (phase_r)
        PH_IDLE, PH_SKIP: phase_nxt = phase_r;
        PH_RX:
        begin
          if (scl_rise && bit_cnt_r != `BITS_PER_BYTE)
          begin
            shift_nxt = {shift_r[6:0], sda_s};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          else if (scl_fall && bit_cnt_r == `BITS_PER_BYTE)
          begin
            phase_nxt = byte_ok ? PH_ACK : PH_SKIP;
            oe_n_nxt = !byte_ok;
          end
        end
        PH_ACK:
        begin
          // Byte is handed on as the ack clock falls
          if (scl_fall)
          begin
            phase_nxt = PH_RX;
            oe_n_nxt = 1'b1;
            bit_cnt_nxt = 4'h0;
            first_nxt = 1'b0;
            push = !first_r; // RL12
            seq_nxt = first_r ? SEQ_CMD : seq_after; // RL1
            if (!first_r && seq_r == SEQ_CMD)
              pd_seq_nxt = shift_r[`PD_SEL_POS];
          end
        end
        default: phase_nxt = PH_IDLE;
      endcase
    end
  end
  // Receiver state
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase_r <= PH_IDLE;
      seq_r <= SEQ_DONE;
      bit_cnt_r <= 4'h0;
      shift_r <= `BYTE_RESET;
      first_r <= 1'b0;
      pd_seq_r <= 1'b0;
      oe_n_r <= 1'b1;
    end
    else
    begin
      phase_r <= phase_nxt;
      seq_r <= seq_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      first_r <= first_nxt;
      pd_seq_r <= pd_seq_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end
  assign sda_oe_n_o = oe_n_r;
  // Open-drain: only ever drives low
  assign sda_o = 1'b0;

  // ==========================================================
  // Byte buffer; a full buffer turns into a not-acknowledge
  logic buf_valid;
  logic buf_ready;
  logic [9:0] buf_data;
  logic pop;
  two_entry_buffer #(.WIDTH(10), .DEPTH(2)) u_buf (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(push),
    .in_ready_o(in_ready),
    .in_data_i({seq_r == SEQ_CMD, seq_r == SEQ_LO, shift_r}),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o(buf_data)
  );
  assign pop = buf_valid && buf_ready;

  // ==========================================================
  // Command, high and low byte holding registers
  logic [7:0] cmd_r;
  logic [7:0] high_r;
  logic [7:0] low_r;
  logic apply_r;
  // Decoder stalls the buffer for the cycle it applies an update
  assign buf_ready = !apply_r;
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cmd_r <= `BYTE_RESET;
      high_r <= `BYTE_RESET;
      low_r <= `BYTE_RESET;
      apply_r <= 1'b0;
    end
    else
    begin
      apply_r <= pop && buf_data[8]; // RL12
      if (pop && buf_data[9])
        cmd_r <= buf_data[7:0]; // RL1
      else if (pop && buf_data[8])
        low_r <= buf_data[7:0];
      else if (pop)
        high_r <= buf_data[7:0];
    end
  end

  // ==========================================================
  // Command field decode; bits 7, 6 and 3 play no part
  logic [1:0] mode;
  logic [1:0] chan;
  logic pd;
  logic [1:0] code;
  logic [11:0] data12;
  logic m_stage;
  logic m_one;
  logic m_all;
  logic m_bc;
  assign mode = {cmd_r[`LOAD_UPPER_POS], cmd_r[`LOAD_LOWER_POS]}; // RL22
  assign chan = {cmd_r[`PICK_UPPER_POS], cmd_r[`PICK_LOWER_POS]};
  assign pd = cmd_r[`PD_SEL_POS];
  assign code = high_r[`PD_CODE_MSB:`PD_CODE_LSB]; // RL3
  assign data12 = {high_r, low_r[7:4]}; // RL10 RL11
  assign m_stage = apply_r && (mode == `MODE_STAGE);
  assign m_one = apply_r && (mode == `MODE_LOAD_ONE);
  assign m_all = apply_r && (mode == `MODE_LOAD_ALL);
  assign m_bc = apply_r && (mode == `MODE_BCAST);

  // ==========================================================
  // Per-channel staging and output registers
  chan_word_t stage_r [4];
  chan_word_t out_r [4];
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_chan
      logic hit;
      logic wr_stage;
      chan_word_t stage_nxt;
      chan_word_t out_nxt;
      chan_word_t new_word;
      chan_word_t pd_out;
      assign hit = (chan == 2'(i)); // RL2
      // Power-down keeps data bits and replaces the code bits
      assign new_word = pd ? {code, stage_r[i][11:0]} : {2'h0, data12}; // RL3 RL16
      assign pd_out = {code, out_r[i][11:0]}; // RL17
      assign wr_stage = hit && (m_stage || m_all || (m_one && !pd)); // RL2 RL4 RL6
      assign stage_nxt = wr_stage ? new_word : stage_r[i];
      // Serial updates override a load pin edge in the same cycle
      always_comb
      begin
        out_nxt = upd_rise ? stage_r[i] : out_r[i]; // RL14
        if (m_one && hit)
          out_nxt = pd ? pd_out : new_word; // RL4 RL5
        else if (m_all)
          out_nxt = stage_nxt; // RL6
        else if (m_bc && !chan[1])
          out_nxt = stage_r[i]; // RL7
        else if (m_bc)
          out_nxt = pd ? pd_out : {2'h0, data12}; // RL8 RL9
      end
      always_ff @(posedge sys_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          stage_r[i] <= `CHAN_RESET; // RL13 RL22
          out_r[i] <= `CHAN_RESET;
        end
        else
        begin
          stage_r[i] <= stage_nxt;
          out_r[i] <= out_nxt;
        end
      end
    end
  endgenerate
  assign output_channel_a_o = out_r[0];
  assign output_channel_b_o = out_r[1];
  assign output_channel_c_o = out_r[2];
  assign output_channel_d_o = out_r[3];

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  cmd_capture_a: assert property (pop && buf_data[9] |=> cmd_r == $past(buf_data[7:0]))
    else $error("command byte not captured"); // RL1
  stage_data_a: assert property (m_stage && !pd |=> stage_r[chan] == {2'h0, data12})
    else $error("staging data write wrong"); // RL2
  stage_pd_a: assert property (m_stage && pd |=> stage_r[chan][13:12] == code)
    else $error("staging power-down code wrong"); // RL3
  load_one_a: assert property (m_one && !pd |=> out_r[chan] == stage_r[chan])
    else $error("single load mismatch"); // RL4
  pd_one_a: assert property (m_one && pd |=> out_r[chan][13:12] == code
    && stage_r[chan] == $past(stage_r[chan]))
    else $error("single power-down wrong"); // RL5
  load_all_a: assert property (m_all |=> out_r[0] == stage_r[0] && out_r[3] == stage_r[3])
    else $error("load-all mismatch"); // RL6
  bcast_stored_a: assert property (m_bc && !chan[1] |=> out_r[1] == $past(stage_r[1]))
    else $error("broadcast stored load wrong"); // RL7
  bcast_data_a: assert property (m_bc && chan[1] && !pd |=> out_r[2] == {2'h0, data12}
    && out_r[0] == out_r[2])
    else $error("broadcast data load wrong"); // RL8
  bcast_pd_a: assert property (m_bc && chan[1] && pd |=> out_r[3][13:12] == code)
    else $error("broadcast power-down wrong"); // RL9
  async_load_a: assert property (upd_rise && !apply_r |=> out_r[2] == $past(stage_r[2]))
    else $error("load pin did not copy"); // RL14
  addr_ack_a: assert property (phase_r == PH_RX && first_r && scl_fall
    && bit_cnt_r == `BITS_PER_BYTE && !addr_match |=> oe_n_r)
    else $error("acked foreign address"); // RL18
  update_time_a: assert property (push && seq_r == SEQ_LO |-> ##[1:3] apply_r)
    else $error("update late after ack"); // RL12
endmodule : quad_dac_update
`default_nettype wire

//--- quad_dac_params.svh
// Constants for the quad converter command and update logic
`ifndef QUAD_DAC_PARAMS_SVH
`define QUAD_DAC_PARAMS_SVH
// Fixed upper five bits of the seven-bit write address
`define DEV_ADDR_PREFIX 5'h13
// Command byte field positions
`define LOAD_UPPER_POS 5
`define LOAD_LOWER_POS 4
`define PICK_UPPER_POS 2
`define PICK_LOWER_POS 1
`define PD_SEL_POS 0
// Power-down code position inside the high data byte
`define PD_CODE_MSB 7
`define PD_CODE_LSB 6
// Load mode encodings
`define MODE_STAGE 2'h0
`define MODE_LOAD_ONE 2'h1
`define MODE_LOAD_ALL 2'h2
`define MODE_BCAST 2'h3
// Bits in one byte, ack slot follows
`define BITS_PER_BYTE 4'h8
// Reset values
`define CHAN_RESET 14'h0000
`define BYTE_RESET 8'h00
`endif

//--- quad_dac_pkg.sv
// Types shared by the quad converter command and update logic
package quad_dac_pkg;
  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_RX = 4'h2,
    PH_ACK = 4'h4,
    PH_SKIP = 4'h8
  } link_phase_e;
  typedef enum logic [3:0] {
    SEQ_CMD = 4'h1,
    SEQ_HI = 4'h2,
    SEQ_LO = 4'h4,
    SEQ_DONE = 4'h8
  } byte_seq_e;
  typedef logic [13:0] chan_word_t;
endpackage : quad_dac_pkg

//--- pin_sync.sv
// Two-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);
  // ==========================================================
  // Per-bit stages; the first flop feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_r;
      logic hold_r;
      always_ff @(posedge sys_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end
        else
        begin
          meta_r <= pin_i[i];
          hold_r <= meta_r;
        end
      end
      assign sync_o[i] = hold_r;
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

//--- two_entry_buffer.sv
// Small FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic do_wr;
  logic do_rd;
  // ==========================================================
  // Handshake decode
  assign in_ready_o = (count_r != FULL);
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;
  // Storage has no reset; entries are only read once written
  always_ff @(posedge sys_clk_i)
  begin
    if (do_wr)
      mem_r[wr_ptr_r] <= in_data_i;
  end
  // Pointers and occupancy
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      if (do_rd)
        rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
      if (do_wr && !do_rd)
        count_r <= count_r + 1'b1;
      else if (do_rd && !do_wr)
        count_r <= count_r - 1'b1;
    end
  end
endmodule : two_entry_buffer
`default_nettype wire

//--- dac_bus_master.sv
// Two-wire bus master model that writes the converter over its link
`timescale 1ns/1ps
`default_nettype none
module dac_bus_master (
  input wire logic sys_clk_i,
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ==================================================
  // Bus timing
  // Idle bus: clock stands high, data released to the pull-up
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Quarter of a 400 ns bit; every move lands just after a clock edge
  task automatic qtr();
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : qtr
  // One bit slot; data moves late in the low phase so an ack release lands first
  task automatic bit_slot(input logic low, output logic seen);
    qtr();
    qtr();
    sda_low_o = low;
    qtr();
    scl_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    seen = sda_line_i;
    @(posedge sys_clk_i);
    #1;
    scl_o = 1'b0;
  endtask : bit_slot
  // ==================================================
  // Framing
  // Start, or repeated start when the clock is low
  task automatic start_cond();
    qtr();
    sda_low_o = 1'b0;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_low_o = 1'b1;
    qtr();
    scl_o = 1'b0;
  endtask : start_cond
  // Stop, then the bus stands idle
  task automatic stop_cond();
    qtr();
    sda_low_o = 1'b1;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_low_o = 1'b0;
    qtr();
  endtask : stop_cond
  // Byte out, most significant bit first, then the slave's ack slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(~b[i], s);
    bit_slot(1'b0, s);
    ack = ~s;
  endtask : send_byte
endmodule : dac_bus_master
`default_nettype wire

//--- quad_dac_update_tb.sv
// Self-checking testbench for the quad converter update logic
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_params.svh"
`define CHECK(nm, exp, got) \
  begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module quad_dac_update_tb
  import quad_dac_pkg::*;
;
  // ==================================================
  // Signals and expected state
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic scl, sda_low, sda_line, sda_o, sda_oe_n, sel_hi, sel_lo, load_pin;
  logic [13:0] outs [4];
  chan_word_t stage [4];
  chan_word_t dac [4];
  int errors = 0;
  int comparisons = 0;
  // Wire has a pull-up; either party may pull it low
  assign sda_line = !(sda_low || (!sda_oe_n && !sda_o));
  initial
  begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  quad_dac_update u_quad_dac_update (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .device_select_upper_i(sel_hi),
    .device_select_lower_i(sel_lo), .async_update_pin_i(load_pin),
    .output_channel_a_o(outs[0]), .output_channel_b_o(outs[1]),
    .output_channel_c_o(outs[2]), .output_channel_d_o(outs[3])
  );
  dac_bus_master u_dac_bus_master (
    .sys_clk_i(sys_clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_low_o(sda_low)
  );
  // ==================================================
  // Expectation and checks
  // Reference update for one high/low pair under a command byte
  function automatic void apply(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l);
    chan_word_t w;
    int ch;
    ch = int'(c[2:1]);
    w = c[0] ? {h[7:6], stage[ch][11:0]} : {2'b00, h, l[7:4]};
    case (c[5:4])
      2'h0: stage[ch] = w;
      2'h1:
      begin
        if (!c[0]) stage[ch] = w;
        dac[ch] = c[0] ? {h[7:6], dac[ch][11:0]} : w;
      end
      2'h2:
      begin
        stage[ch] = w;
        dac = stage;
      end
      default:
        for (int i = 0; i < 4; i++)
          dac[i] = !c[2] ? stage[i] : c[0] ? {h[7:6], dac[i][11:0]} : {2'b00, h, l[7:4]};
    endcase
  endfunction : apply
  // Outputs settle a few clocks after the last ack slot; look just past the edge
  task automatic compare_all();
    repeat (8) @(posedge sys_clk_i);
    #1;
    for (int i = 0; i < 4; i++)
      `CHECK("output", dac[i], outs[i])
  endtask : compare_all
  // Addressed write; optional extra byte after the data must be refused
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] d[$], input bit extra);
    logic ack;
    u_dac_bus_master.start_cond();
    u_dac_bus_master.send_byte({`DEV_ADDR_PREFIX, sel_hi, sel_lo, 1'b0}, ack);
    `CHECK("address ack", 1'b1, ack)
    u_dac_bus_master.send_byte(cmd, ack);
    `CHECK("command ack", 1'b1, ack)
    foreach (d[i])
    begin
      u_dac_bus_master.send_byte(d[i], ack);
      `CHECK("data ack", 1'b1, ack)
      if (i % 2 == 1) apply(cmd, d[i-1], d[i]);
      else compare_all();
    end
    if (extra)
    begin
      u_dac_bus_master.send_byte(8'h5A, ack);
      `CHECK("extra ack", 1'b0, ack)
    end
    u_dac_bus_master.stop_cond();
    compare_all();
  endtask : xfer
  // Data writes to all four staging registers under load mode 00
  task automatic stage_all();
    for (int ch = 0; ch < 4; ch++)
      xfer({4'h0, 1'($urandom), 2'(ch), 1'b0}, '{8'($urandom), 8'($urandom)}, 1'b0);
  endtask : stage_all
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  // ==================================================
  // Main sequence
  initial
  begin
    logic ack;
    logic [7:0] c;
    logic [7:0] q[$];
    void'($urandom(32'h61B43C9A));
    sel_hi = 1'($urandom);
    sel_lo = 1'($urandom);
    load_pin = 1'b0;
    stage = '{default: '0};
    dac = '{default: '0};
    repeat (2) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    compare_all();
    // Wrong device select, then a read of the right one: both ignored
    for (int k = 0; k < 2; k++)
    begin
      u_dac_bus_master.start_cond();
      c = k ? {`DEV_ADDR_PREFIX, sel_hi, sel_lo, 1'b1} : {`DEV_ADDR_PREFIX, ~sel_hi, sel_lo, 1'b0};
      u_dac_bus_master.send_byte(c, ack);
      `CHECK("refused ack", 1'b0, ack)
      u_dac_bus_master.send_byte(8'h10, ack);
      u_dac_bus_master.send_byte(8'hAB, ack);
      u_dac_bus_master.send_byte(8'hC0, ack);
      u_dac_bus_master.stop_cond();
      compare_all();
    end
    // Broadcast modes; top bits set in 8'hF9 and bit three in 8'hF9 and 8'h3C to show they are ignored
    stage_all();
    xfer(8'hF9, '{8'hC0, 8'h00}, 1'b0);
    xfer(8'h3C, '{8'h7E, 8'hF3}, 1'b0);
    xfer(8'h35, '{8'h80, 8'h00}, 1'b1);
    stage_all();
    // Several pairs under one command byte
    xfer(8'h12, '{8'h11, 8'h20, 8'hFE, 8'hDF}, 1'b0);
    // Random modes 00 to 10, random channel, data or power-down
    repeat (40)
    begin
      c = {2'($urandom), 2'($urandom_range(2)), 1'($urandom), 2'($urandom), 1'($urandom)};
      q = c[0] ? '{{2'($urandom), 6'h00}, 8'h00} : '{8'($urandom), 8'($urandom)};
      xfer(c, q, c[0] & 1'($urandom));
    end
    // Load pin raised only once staging is written
    stage_all();
    @(posedge sys_clk_i);
    #1 load_pin = 1'b1;
    dac = stage;
    compare_all();
    load_pin = 1'b0;
    compare_all();
    finish_test();
  end
  // Watchdog against a hung run
  initial
  begin
    repeat (100000) @(posedge sys_clk_i);
    errors++;
    finish_test();
  end
endmodule : quad_dac_update_tb
`default_nettype wire
